// file: core/slwr_waveform_regs.sv
// Segment LCD waveform register store with phase sequencer and Wishbone slave
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

module slwr_waveform_regs #(
   parameter int PHASE_DIV = slwr_pkg::SLWR_PHASE_DIV_DEF, // Clocks per phase step
   parameter int NUM_PINS = slwr_pkg::SLWR_NUM_PINS        // LCD pins served
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [slwr_pkg::SLWR_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pin side towards the glass
   output logic [NUM_PINS-1:0] pin_lcd_mode,
   output logic [NUM_PINS-1:0] pin_is_backplane,
   output logic [NUM_PINS-1:0] pin_drive_on,
   output logic [2:0] phase_index
);

   // ==========================================================
   // Declarations
   // ==========================================================
   localparam int DIV_W = $clog2(PHASE_DIV + 1); // Divider width

   // Waveform store, one byte per pin, bit n is phase n
   logic [slwr_pkg::SLWR_NUM_PHASES-1:0] pin_waveform_reg [NUM_PINS];
   // Control and configuration
   logic module_enable_reg;                  // Module enable
   logic [2:0] duty_reg;                     // Last phase index in the frame
   logic [NUM_PINS-1:0] pin_enable_reg;      // Per-pin LCD enable
   logic [NUM_PINS-1:0] backplane_select_reg; // Per-pin backplane select
   logic blank_reg;                          // Blank display mode
   // Sequencer state
   logic [DIV_W-1:0] div_reg;                // Phase step divider
   logic [2:0] phase_reg;                    // Current phase
   logic phase_tick;                         // Divider terminal count
   // Bus handling
   logic ack_reg;                            // Acknowledge
   logic [31:0] rdata_reg;                   // Read data
   logic bus_req;                            // Cycle is requesting
   logic wr_fire;                            // Write takes effect this edge
   logic [5:0] word_idx;                     // Word index of the access
   logic wave_hit;                           // Index falls on a waveform byte
   logic [4:0] wave_sel;                     // Waveform register selected
   logic [31:0] rdata_next;                  // Read mux result
   // Output registers
   logic [NUM_PINS-1:0] pin_lcd_mode_reg;
   logic [NUM_PINS-1:0] pin_is_backplane_reg;
   logic [NUM_PINS-1:0] pin_drive_on_reg;

   // ==========================================================
   // Bus decode
   // ==========================================================

   // Request seen while cycle and strobe are both high
   assign bus_req = wb_cyc_i & wb_stb_i;
   // Writes land on the edge that the master samples ack
   assign wr_fire = bus_req & wb_we_i & ack_reg;
   // Word index from the byte address
   assign word_idx = wb_adr_i[7:2];
   // Waveform window check
   assign wave_hit = (word_idx <= slwr_pkg::SLWR_IDX_WAVE_LAST);
   // Low bits select the waveform byte
   assign wave_sel = word_idx[4:0];

   // Acknowledge one cycle after request, drop after one cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
      end
   end

   // Read mux; unmapped words read as zero
   always_comb begin
      rdata_next = 32'h00000000;
      if (wave_hit) begin
         // Phase H on bit 7 down to phase A on bit 0
         rdata_next[7:0] = pin_waveform_reg[wave_sel];
      end else begin
         case (word_idx)
            slwr_pkg::SLWR_IDX_CTRL: begin
               rdata_next[slwr_pkg::SLWR_CTRL_EN_BIT] = module_enable_reg;
               rdata_next[slwr_pkg::SLWR_CTRL_DUTY_LSB +: 3] = duty_reg;
            end
            slwr_pkg::SLWR_IDX_PEN: begin
               rdata_next[NUM_PINS-1:0] = pin_enable_reg;
            end
            slwr_pkg::SLWR_IDX_BPSEL: begin
               rdata_next[NUM_PINS-1:0] = backplane_select_reg;
            end
            slwr_pkg::SLWR_IDX_BLINK: begin
               rdata_next[slwr_pkg::SLWR_BLINK_BLANK_BIT] = blank_reg;
            end
            slwr_pkg::SLWR_IDX_STATUS: begin
               rdata_next[slwr_pkg::SLWR_STAT_EN_BIT] = module_enable_reg;
               rdata_next[slwr_pkg::SLWR_STAT_PHASE_LSB +: 3] = phase_reg;
            end
            default: begin
               rdata_next = 32'h00000000;
            end
         endcase
      end
   end

   // Read data captured alongside the acknowledge
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_reg <= 32'h00000000;
      end else if (bus_req & ~ack_reg) begin
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // Waveform store
   // ==========================================================

   // No reset: contents are unknown until software writes them
   // Only lane 0 is stored, so a byte write on lane 0 is the path
   always_ff @(posedge clk) begin
      if (wr_fire && wave_hit && wb_sel_i[0]) begin
         // Eight phase bits per pin
         pin_waveform_reg[wave_sel] <= wb_dat_i[7:0];
      end
   end

   // ==========================================================
   // Control registers
   // ==========================================================

   // Module enable and duty
   always_ff @(posedge clk) begin
      if (srst) begin
         module_enable_reg <= 1'b0;
         duty_reg <= slwr_pkg::SLWR_DUTY_RST;
      end else if (wr_fire && word_idx == slwr_pkg::SLWR_IDX_CTRL && wb_sel_i[0]) begin
         module_enable_reg <= wb_dat_i[slwr_pkg::SLWR_CTRL_EN_BIT];
         duty_reg <= wb_dat_i[slwr_pkg::SLWR_CTRL_DUTY_LSB +: 3];
      end
   end

   // Per-pin LCD enables, written lane by lane
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_enable_reg <= slwr_pkg::SLWR_PINS_RST;
      end else if (wr_fire && word_idx == slwr_pkg::SLWR_IDX_PEN) begin
         for (int b = 0; b < NUM_PINS; b++) begin
            if (wb_sel_i[b / 8]) begin
               pin_enable_reg[b] <= wb_dat_i[b];
            end
         end
      end
   end

   // Per-pin backplane selects, written lane by lane
   always_ff @(posedge clk) begin
      if (srst) begin
         backplane_select_reg <= slwr_pkg::SLWR_PINS_RST;
      end else if (wr_fire && word_idx == slwr_pkg::SLWR_IDX_BPSEL) begin
         for (int b = 0; b < NUM_PINS; b++) begin
            if (wb_sel_i[b / 8]) begin
               backplane_select_reg[b] <= wb_dat_i[b];
            end
         end
      end
   end

   // Blank display mode bit
   always_ff @(posedge clk) begin
      if (srst) begin
         blank_reg <= 1'b0;
      end else if (wr_fire && word_idx == slwr_pkg::SLWR_IDX_BLINK && wb_sel_i[0]) begin
         blank_reg <= wb_dat_i[slwr_pkg::SLWR_BLINK_BLANK_BIT];
      end
   end

   // ==========================================================
   // Phase sequencer
   // ==========================================================

   // Terminal count of the phase divider
   assign phase_tick = (div_reg == DIV_W'(PHASE_DIV - 1));

   // Divider runs only while the module is enabled
   always_ff @(posedge clk) begin
      if (srst) begin
         div_reg <= '0;
      end else if (!module_enable_reg || phase_tick) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + DIV_W'(1);
      end
   end

   // Step A onward through the duty, then wrap to A
   // Wrap also covers a duty lowered below the current phase
   always_ff @(posedge clk) begin
      if (srst) begin
         phase_reg <= slwr_pkg::SLWR_PHASE_RST;
      end else if (!module_enable_reg) begin
         phase_reg <= slwr_pkg::SLWR_PHASE_RST;
      end else if (phase_tick) begin
         if (phase_reg >= duty_reg) begin
            phase_reg <= slwr_pkg::SLWR_PHASE_RST;
         end else begin
            phase_reg <= phase_reg + 3'h1;
         end
      end
   end

   // ==========================================================
   // Pin drive
   // ==========================================================

   // Each pin: mode, role and drive level for the current phase
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_lcd_mode_reg <= '0;
         pin_is_backplane_reg <= '0;
         pin_drive_on_reg <= '0;
      end else begin
         for (int p = 0; p < NUM_PINS; p++) begin
            // Both enables needed; disabled module masks the pin bits
            pin_lcd_mode_reg[p] <= pin_enable_reg[p] & module_enable_reg;
            // Backplane role only on an LCD pin
            pin_is_backplane_reg[p] <= pin_enable_reg[p] & module_enable_reg & backplane_select_reg[p];
            if (!(pin_enable_reg[p] && module_enable_reg)) begin
               // Not an LCD pin
               pin_drive_on_reg[p] <= 1'b0;
            end else if (backplane_select_reg[p]) begin
               // Backplane active in phases whose bit is set
               pin_drive_on_reg[p] <= pin_waveform_reg[p][phase_reg];
            end else if (blank_reg) begin
               // Blank: waveform data ignored, segments off
               pin_drive_on_reg[p] <= 1'b0;
            end else begin
               // Frontplane segment on for a one, off for a zero
               pin_drive_on_reg[p] <= pin_waveform_reg[p][phase_reg];
            end
         end
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign pin_lcd_mode = pin_lcd_mode_reg;
   assign pin_is_backplane = pin_is_backplane_reg;
   assign pin_drive_on = pin_drive_on_reg;
   assign phase_index = phase_reg;

   // ==========================================================
   // Assertions
   // ==========================================================

   // Byte write on lane 0 lands in the selected waveform register
   AST_WAVE_WRITE: assert property (@(posedge clk) disable iff (srst)
      (wr_fire && wave_hit && wb_sel_i[0]) |=> (pin_waveform_reg[$past(wave_sel)] == $past(wb_dat_i[7:0])))
      else $error("waveform byte write not stored");

   // Register bit n drives the pin in phase n, bit 7 being phase H
   AST_PHASE_BIT_ORDER: assert property (@(posedge clk) disable iff (srst)
      (pin_enable_reg[0] && module_enable_reg && backplane_select_reg[0])
      |=> (pin_drive_on[0] == $past(pin_waveform_reg[0][phase_reg])))
      else $error("backplane drive does not follow phase bit");

   // Frontplane pin 1 follows its phase bit when not blanked
   AST_FRONT_SEG: assert property (@(posedge clk) disable iff (srst)
      (pin_enable_reg[1] && module_enable_reg && !backplane_select_reg[1] && !blank_reg)
      |=> (pin_drive_on[1] == $past(pin_waveform_reg[1][phase_reg])))
      else $error("frontplane segment does not follow waveform");

   // Blank mode leaves no frontplane driven on
   AST_BLANK_CLEAR: assert property (@(posedge clk) disable iff (srst)
      blank_reg |=> ((pin_drive_on & ~pin_is_backplane) == '0))
      else $error("segment lit during blank mode");

   // LCD mode needs both the pin enable and the module enable
   AST_LCD_GATE: assert property (@(posedge clk) disable iff (srst)
      ##1 (pin_lcd_mode == ($past(pin_enable_reg) & {NUM_PINS{$past(module_enable_reg)}})))
      else $error("lcd mode not gated by both enables");

   // Module disabled: no pin active, sequencer held at phase A
   AST_DISABLED_IDLE: assert property (@(posedge clk) disable iff (srst)
      (!module_enable_reg ##1 !module_enable_reg)
      |-> (pin_lcd_mode == '0 && pin_is_backplane == '0 && phase_reg == 3'h0))
      else $error("pin active while module disabled");

   // Last phase of the duty wraps to phase A on the next step
   AST_PHASE_WRAP: assert property (@(posedge clk) disable iff (srst)
      (module_enable_reg && phase_tick && phase_reg >= duty_reg) |=> (phase_reg == 3'h0))
      else $error("phase did not wrap at end of duty");

   // Phase advances by exactly one below the duty limit
   AST_PHASE_STEP: assert property (@(posedge clk) disable iff (srst)
      (module_enable_reg && phase_tick && phase_reg < duty_reg) |=> (phase_reg == $past(phase_reg) + 3'h1))
      else $error("phase did not advance by one");

   // Backplane role only for enabled pins with select set
   AST_BP_ROLE: assert property (@(posedge clk) disable iff (srst)
      ##1 (pin_is_backplane == ($past(pin_enable_reg) & $past(backplane_select_reg)
      & {NUM_PINS{$past(module_enable_reg)}})))
      else $error("backplane role wrong");

   // Acknowledge is a single-cycle answer one edge after the request
   AST_ACK_ONE: assert property (@(posedge clk) disable iff (srst)
      (bus_req && !ack_reg) |=> (ack_reg ##1 !ack_reg))
      else $error("acknowledge not a single pulse");

   // Pins outside the LCD function never drive
   AST_OFF_PIN_QUIET: assert property (@(posedge clk) disable iff (srst)
      ##1 ((pin_drive_on & ~($past(pin_enable_reg) & {NUM_PINS{$past(module_enable_reg)}})) == '0))
      else $error("drive on a pin outside lcd function");

   // Disabled module keeps the phase divider cleared
   AST_DIV_CLEAR: assert property (@(posedge clk) disable iff (srst)
      !module_enable_reg |=> (div_reg == '0))
      else $error("phase divider running while disabled");

   // Between divider steps the phase holds
   AST_PHASE_HOLD: assert property (@(posedge clk) disable iff (srst)
      (module_enable_reg && !phase_tick) |=> $stable(phase_reg))
      else $error("phase moved between steps");

   // Backplane pin keeps its phases through blank mode
   AST_BLANK_BP_KEEP: assert property (@(posedge clk) disable iff (srst)
      (blank_reg && pin_enable_reg[0] && module_enable_reg && backplane_select_reg[0])
      |=> (pin_drive_on[0] == $past(pin_waveform_reg[0][phase_reg])))
      else $error("backplane phase lost in blank mode");

   // Control write sets the module enable bit
   AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (srst)
      (wr_fire && word_idx == slwr_pkg::SLWR_IDX_CTRL && wb_sel_i[0])
      |=> (module_enable_reg == $past(wb_dat_i[slwr_pkg::SLWR_CTRL_EN_BIT])))
      else $error("module enable not written");

   // Blink register write sets the blank bit
   AST_BLANK_WRITE: assert property (@(posedge clk) disable iff (srst)
      (wr_fire && word_idx == slwr_pkg::SLWR_IDX_BLINK && wb_sel_i[0])
      |=> (blank_reg == $past(wb_dat_i[slwr_pkg::SLWR_BLINK_BLANK_BIT])))
      else $error("blank bit not written");

   // Control and status reads return the register mux
   AST_READ_DATA: assert property (@(posedge clk) disable iff (srst)
      (bus_req && !ack_reg && !wave_hit) |=> (wb_dat_o == $past(rdata_next)))
      else $error("read data does not match register");

   // No acknowledge without a request
   AST_ACK_NO_REQ: assert property (@(posedge clk) disable iff (srst)
      !bus_req |=> !ack_reg)
      else $error("acknowledge without request");

endmodule

// file: core/slwr_pkg.sv
// Package with the register map, field positions and reset values of the segment LCD waveform store
package slwr_pkg;

   // ==========================================================
   // Geometry
   // ==========================================================
   localparam int SLWR_NUM_PINS = 22;   // LCD pins served
   localparam int SLWR_NUM_PHASES = 8;  // Backplane phases A..H
   localparam int SLWR_ADR_W = 8;       // Byte address width on the bus

   // ==========================================================
   // Register word indices (byte address = index * 4)
   // ==========================================================
   localparam logic [5:0] SLWR_IDX_WAVE_FIRST = 6'h00;  // pin_waveform_0
   localparam logic [5:0] SLWR_IDX_WAVE_LAST = 6'h15;   // pin_waveform_21
   localparam logic [5:0] SLWR_IDX_CTRL = 6'h18;        // driver_control_0
   localparam logic [5:0] SLWR_IDX_PEN = 6'h19;         // pin_enable_reg
   localparam logic [5:0] SLWR_IDX_BPSEL = 6'h1A;       // backplane_select_reg
   localparam logic [5:0] SLWR_IDX_BLINK = 6'h1B;       // blink_control_reg
   localparam logic [5:0] SLWR_IDX_STATUS = 6'h1C;      // Phase status, read only

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int SLWR_CTRL_EN_BIT = 7;     // module_enable
   localparam int SLWR_CTRL_DUTY_LSB = 0;   // Duty field, 3 bits
   localparam int SLWR_BLINK_BLANK_BIT = 5; // Blank display mode
   localparam int SLWR_STAT_EN_BIT = 7;     // Enable as seen by the sequencer
   localparam int SLWR_STAT_PHASE_LSB = 0;  // Current phase, 3 bits

   // ==========================================================
   // Reset values and counts
   // ==========================================================
   localparam logic [2:0] SLWR_DUTY_RST = 3'h0;       // One backplane
   localparam logic [21:0] SLWR_PINS_RST = 22'h000000; // No pins enabled
   localparam logic [2:0] SLWR_PHASE_RST = 3'h0;      // Phase A
   localparam int SLWR_PHASE_DIV_DEF = 256;           // Clocks per phase step

endpackage

// file: testbench/slwr_glass_model.sv
// Behavioural model of the LCD glass facing the waveform store pins
`timescale 1ns/1ps

module slwr_glass_model #(
   parameter int NUM_PINS = 22 // Pins wired to the glass
) (
   // Pin drive seen from the glass
   input wire logic [NUM_PINS-1:0] pin_lcd_mode,
   input wire logic [NUM_PINS-1:0] pin_is_backplane,
   input wire logic [NUM_PINS-1:0] pin_drive_on,
   // Segments lit in this phase, one per frontplane pin
   output logic [NUM_PINS-1:0] seg_lit
);
   // ==========================================================
   // Segment lighting
   // ==========================================================
   logic bp_active; // Some backplane electrode energised

   // A segment lights only across an active backplane and an on frontplane
   always_comb begin
      bp_active = |(pin_lcd_mode & pin_is_backplane & pin_drive_on);
      seg_lit = pin_lcd_mode & ~pin_is_backplane & pin_drive_on & {NUM_PINS{bp_active}};
   end
endmodule

// file: testbench/slwr_waveform_regs_test.sv
// Self-checking bench for the segment LCD waveform store
`timescale 1ns/1ps

module slwr_waveform_regs_test;
   // ==========================================================
   // Signals
   // ==========================================================
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [21:0] pin_lcd_mode;
   logic [21:0] pin_is_backplane;
   logic [21:0] pin_drive_on;
   logic [21:0] seg_lit;
   logic [2:0] phase_index;
   logic [31:0] rd;
   int miscompares = 0;
   int cmp_count = 0;
   logic [7:0] wave [4] = '{8'h81, 8'h5A, 8'hC3, 8'h3C}; // Pin 0 is the backplane

   // ==========================================================
   // Design and glass
   // ==========================================================
   slwr_waveform_regs #(.PHASE_DIV(4), .NUM_PINS(22)) i_dut (
      .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .pin_lcd_mode(pin_lcd_mode), .pin_is_backplane(pin_is_backplane),
      .pin_drive_on(pin_drive_on), .phase_index(phase_index));
   slwr_glass_model #(.NUM_PINS(22)) i_glass (
      .pin_lcd_mode(pin_lcd_mode), .pin_is_backplane(pin_is_backplane),
      .pin_drive_on(pin_drive_on), .seg_lit(seg_lit));

   // Clock at 200 MHz
   initial begin
      forever #2.5 clk = ~clk;
   end

   // ==========================================================
   // Tasks
   // ==========================================================
   // Compare one value and count it
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One classic Wishbone cycle, entered and left just after a rising edge
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
         output logic [31:0] rdat);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= we ? 4'h1 : 4'hF; // Byte writes only
      wb_wdat <= wdat;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      // Acknowledge comes one cycle after the request is first seen
      chk("ack wait", 32'h00000002, 32'(n));
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask

   // Wait for the sequencer to step, then let the pins settle
   task automatic wait_phase();
      logic [2:0] old;
      int n;
      old = phase_index;
      n = 0;
      while (phase_index === old && n < 12) begin
         @(posedge clk);
         n++;
      end
      repeat (2) @(posedge clk);
   endtask

   // Pin outputs against the waveform table for one phase
   task automatic check_pins(input int p, input logic blank);
      logic [21:0] e;
      e = 22'h000000;
      for (int n = 0; n < 4; n++) begin
         e[n] = wave[n][p] & ~(blank & (n != 0));
      end
      chk("phase", 32'(p), {29'h0, phase_index});
      chk("mode", 32'h0000000F, {10'h0, pin_lcd_mode});
      chk("backplane", 32'h00000001, {10'h0, pin_is_backplane});
      chk("drive", {10'h0, e}, {10'h0, pin_drive_on});
      chk("lit", {10'h0, e & 22'h00000E & {22{e[0]}}}, {10'h0, seg_lit});
   endtask

   // Verdict and end of run
   task automatic conclude();
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Watchdog over the expected run time
   initial begin
      #20000;
      miscompares++;
      conclude();
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk("reset pins", 32'h0, {10'h0, pin_lcd_mode | pin_drive_on});
      // Waveform store holds all eight bits; no reset value assumed
      for (int n = 0; n < 4; n++) begin
         wb_xfer(1'b1, 8'(4 * n), {24'h0, wave[n]}, rd);
      end
      for (int n = 0; n < 4; n++) begin
         wb_xfer(1'b0, 8'(4 * n), 32'h0, rd);
         chk("wave read", {24'h0, wave[n]}, rd);
      end
      wb_xfer(1'b0, 8'h74, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      // Full configuration before enabling
      wb_xfer(1'b1, 8'h64, 32'h0000000F, rd);
      wb_xfer(1'b1, 8'h68, 32'h00000001, rd);
      wb_xfer(1'b0, 8'h64, 32'h0, rd);
      chk("pin enable read", 32'h0000000F, rd);
      wb_xfer(1'b0, 8'h68, 32'h0, rd);
      chk("backplane read", 32'h00000001, rd);
      chk("off mode", 32'h0, {10'h0, pin_lcd_mode | pin_is_backplane | pin_drive_on});
      // Eight phases, then three, each wrapping once
      for (int j = 0; j < 2; j++) begin
         int d;
         d = (j == 0) ? 7 : 2;
         wb_xfer(1'b1, 8'h60, 32'(8'h80 | d), rd);
         repeat (2) @(posedge clk);
         for (int k = 0; k <= d + 1; k++) begin
            if (k > 0) begin
               wait_phase();
            end
            check_pins(k % (d + 1), 1'b0);
         end
         wb_xfer(1'b1, 8'h60, 32'h0, rd);
         @(posedge clk);
         chk("disabled", 32'h0, {10'h0, pin_lcd_mode | pin_drive_on});
         chk("disabled phase", 32'h0, {29'h0, phase_index});
      end
      // Blank display over all eight phases, A through H
      wb_xfer(1'b1, 8'h6C, 32'h00000020, rd);
      wb_xfer(1'b0, 8'h6C, 32'h0, rd);
      chk("blank read", 32'h00000020, rd);
      wb_xfer(1'b1, 8'h60, 32'h00000087, rd);
      repeat (2) @(posedge clk);
      check_pins(0, 1'b1);
      for (int k = 1; k < 8; k++) begin
         wait_phase();
         check_pins(k, 1'b1);
      end
      // Status taken on the edge where phase H is still current
      wb_xfer(1'b0, 8'h70, 32'h0, rd);
      chk("status read", 32'h00000087, rd);
      wb_xfer(1'b0, 8'h60, 32'h0, rd);
      chk("control read", 32'h00000087, rd);
      conclude();
   end
endmodule
